/* File: test_thermostat_status_and_readout.sv */
// Purpose: Self-checking bench for the thermostat status and readout block
// Assumes: Shortened bus reset and presence counts
// Notes:   Thermostat phase feeds results straight into the core ports
`timescale 1ns/1ps
`default_nettype none
`define TSR_CHK(got, exp) \
  begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_thermostat_status_and_readout;
  // Must exceed the 6000-cycle write-0 low time, or every 0 bit reads as a reset
  localparam int RST_C = 6500;
  logic       core_clk;
  logic       sys_rst;
  logic       nvm_clear;
  logic       conv_valid;
  logic [7:0] conv_temp;
  logic [8:0] conv_remain;
  logic [8:0] conv_slope;
  wire        dq_out;
  wire        dq_oe;
  wire        conv_start;
  wire        thermo_mode;
  wire        thermo_active;
  wire        mst_low;
  wire        dq_line = (dq_oe || mst_low) ? 1'b0 : 1'b1;
  int         err_total;
  int         check_count;
  int         pres_at;
  tsr_top #(.RESET_CYC(RST_C), .PRES_CYC(200), .NVW_CYC(50)) dut_u (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .NVM_CLEAR(nvm_clear), .DQ_IN(dq_line),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe), .CONV_START(conv_start), .CONV_VALID(conv_valid),
    .CONV_TEMP(conv_temp), .CONV_REMAIN(conv_remain), .CONV_SLOPE(conv_slope),
    .THERMO_MODE(thermo_mode), .THERMO_ACTIVE(thermo_active));
  tsr_bus_master u_mst (.clk(core_clk), .line(dq_line), .pull_low(mst_low));
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic test_presence();
    `TSR_CHK(thermo_mode, 1'b0)
    `TSR_CHK(dq_out, 1'b0)
    u_mst.bus_reset(RST_C + 100, pres_at);
    `TSR_CHK(pres_at >= 1500 && pres_at <= 6000, 1'b1)
    if (pres_at < 0) stop_test();
    $display("presence test done");
  endtask
  task automatic test_mode_write();
    `TSR_CHK(thermo_mode, 1'b0)
    u_mst.send_byte(8'h0c);
    u_mst.send_byte(8'h04);
    repeat (100) @(posedge core_clk);
    #1 sys_rst = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    // The start request stands for the one cycle after the mode latch
    @(posedge core_clk);
    #1;
    `TSR_CHK(thermo_mode, 1'b1)
    `TSR_CHK(conv_start, 1'b1)
    $display("mode write test done");
  endtask
  task automatic test_thermostat();
    // Trip points are both zero after the erase, so zero itself holds state
    logic [7:0] temps [6] = '{8'h05, 8'h00, 8'hff, 8'h00, 8'h7d, 8'hc9};
    logic       acts  [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++)
    begin
      repeat (2) @(posedge core_clk);
      #1 conv_valid = 1'b1;
      conv_temp = temps[i];
      conv_remain = {1'h0, temps[i]};
      conv_slope = {1'h1, ~temps[i]};
      @(posedge core_clk);
      #1 conv_valid = 1'b0;
      `TSR_CHK(thermo_active, acts[i])
      `TSR_CHK(conv_start, 1'b1)
      @(posedge core_clk);
      #1;
      `TSR_CHK(dq_oe, acts[i])
    end
    $display("thermostat test done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    err_total = 0;
    check_count = 0;
    sys_rst = 1'b1;
    nvm_clear = 1'b1;
    conv_valid = 1'b0;
    conv_temp = 8'h00;
    conv_remain = 9'h000;
    conv_slope = 9'h000;
    repeat (5) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    nvm_clear = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    test_presence();
    test_mode_write();
    test_thermostat();
    stop_test();
  end
endmodule // test_thermostat_status_and_readout
`default_nettype wire

/* File: tsr_bus_master.sv */
// Purpose: Bus master model on the open-drain data line
// Assumes: Line is pulled up; this side only pulls low
// Notes:   Every write slot lasts at least 60 us so the sample window is honoured
`timescale 1ns/1ps
`default_nettype none
module tsr_bus_master (
  // Clock and line
  input  wire logic clk,
  input  wire logic line,
  output var logic  pull_low
);
  initial pull_low = 1'b0;
  task automatic bus_reset(input int low_cyc, output int pres_at);
    pres_at = -1;
    @(posedge clk);
    #1 pull_low = 1'b1;
    repeat (low_cyc) @(posedge clk);
    #1 pull_low = 1'b0;
    for (int i = 0; i < 8000 && pres_at < 0; i++)
    begin
      @(posedge clk);
      if (!line) pres_at = i;
    end
    repeat (400) @(posedge clk);
  endtask
  task automatic send_byte(input logic [7:0] val);
    for (int b = 0; b < 8; b++)
    begin
      @(posedge clk);
      #1 pull_low = 1'b1;
      repeat (val[b] ? 100 : 6000) @(posedge clk);
      #1 pull_low = 1'b0;
      repeat (val[b] ? 5900 : 100) @(posedge clk);
    end
  endtask
endmodule // tsr_bus_master
`default_nettype wire

/* File: tsr_consts.vh */
// Purpose: Shared constants of the thermostat status and readout block
// Assumes: 100 MHz core clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSR_CLK_MHZ        100
`define TSR_RESET_US       480
`define TSR_RESET_CYC      (`TSR_RESET_US * `TSR_CLK_MHZ)
`define TSR_SAMPLE_US      30
`define TSR_SAMPLE_CYC     (`TSR_SAMPLE_US * `TSR_CLK_MHZ)
`define TSR_PWAIT_US       30
`define TSR_PWAIT_CYC      (`TSR_PWAIT_US * `TSR_CLK_MHZ)
`define TSR_PRES_US        120
`define TSR_PRES_CYC       (`TSR_PRES_US * `TSR_CLK_MHZ)
`define TSR_NVW_MS         10
`define TSR_NVW_CYC        (`TSR_NVW_MS * 1000 * `TSR_CLK_MHZ)
`define TSR_CNT_W          20

// ----------------------------------------------------------------
// Function commands
// ----------------------------------------------------------------
`define TSR_CMD_RD_TEMP    8'haa
`define TSR_CMD_START      8'hee
`define TSR_CMD_STOP       8'h22
`define TSR_CMD_WR_UPPER   8'h01
`define TSR_CMD_WR_LOWER   8'h02
`define TSR_CMD_RD_UPPER   8'ha1
`define TSR_CMD_RD_LOWER   8'ha2
`define TSR_CMD_WR_STATUS  8'h0c
`define TSR_CMD_RD_STATUS  8'hac
`define TSR_CMD_RD_COUNT   8'ha0
`define TSR_CMD_LD_COUNT   8'h41

// ----------------------------------------------------------------
// Status/configuration fields (stored part is bits 4..0)
// ----------------------------------------------------------------
`define TSR_ST_DONE        7
`define TSR_ST_ONE         6
`define TSR_ST_BUSY        5
`define TSR_ST_HIGH        4
`define TSR_ST_LOW         3
`define TSR_ST_MODE        2
`define TSR_ST_SENSE       1
`define TSR_ST_SINGLE      0

// Nonvolatile write selects
`define TSR_NV_UPPER       2'h0
`define TSR_NV_LOWER       2'h1
`define TSR_NV_CFG         2'h2

`endif

/* File: tsr_nvm.v */
// Purpose: Nonvolatile store of trip points and stored configuration bits
// Assumes: clear is a factory erase; rst never touches stored contents
// Notes:   Bus writes start a busy window; writes while busy are dropped
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.vh"

module tsr_nvm #(
  parameter integer WRITE_CYC = `TSR_NVW_CYC
)(
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  input  wire       clear,
  // Write port
  input  wire       wr_en,
  input  wire [1:0] wr_sel,
  input  wire [7:0] wr_data,
  // Hardware flag sets
  input  wire       set_high,
  input  wire       set_low,
  // Stored values
  output reg  [7:0] upper,
  output reg  [7:0] lower,
  output reg  [4:0] cfg,
  output reg        busy
);

  localparam [`TSR_CNT_W-1:0] C_WRITE = WRITE_CYC[`TSR_CNT_W-1:0];

  reg [`TSR_CNT_W-1:0] tmr_r;
  wire                 wr_ok;

  assign wr_ok = wr_en & ~busy;

  // ----------------------------------------------------------------
  // Storage: deliberately outside reset so it outlives power cycles
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (clear)
    begin
      upper <= 8'h00;
      lower <= 8'h00;
      cfg   <= 5'h00;
    end
    else
    begin
      if (wr_ok && wr_sel == `TSR_NV_UPPER)
        upper <= wr_data;
      if (wr_ok && wr_sel == `TSR_NV_LOWER)
        lower <= wr_data;
      if (wr_ok && wr_sel == `TSR_NV_CFG)
        cfg[2:0] <= wr_data[2:0];
      // Hardware set wins over a clearing write in the same cycle
      if (set_high)
        cfg[`TSR_ST_HIGH] <= 1'b1;
      else if (wr_ok && wr_sel == `TSR_NV_CFG)
        cfg[`TSR_ST_HIGH] <= wr_data[`TSR_ST_HIGH];
      if (set_low)
        cfg[`TSR_ST_LOW] <= 1'b1;
      else if (wr_ok && wr_sel == `TSR_NV_CFG)
        cfg[`TSR_ST_LOW] <= wr_data[`TSR_ST_LOW];
    end
  end

  // ----------------------------------------------------------------
  // Busy window
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      busy  <= 1'b0;
      tmr_r <= {`TSR_CNT_W{1'b0}};
    end
    else if (wr_ok)
    begin
      busy  <= 1'b1;
      tmr_r <= C_WRITE - 1'b1;
    end
    else if (busy)
    begin
      if (tmr_r == {`TSR_CNT_W{1'b0}})
        busy <= 1'b0;
      else
        tmr_r <= tmr_r - {{(`TSR_CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // tsr_nvm
`default_nettype wire

/* File: tsr_slot.v */
// Purpose: Line timing engine: bus reset, presence, write and read slots
// Assumes: Open-drain line with pull-up; line_in is asynchronous
// Notes:   Read slots for a 0 bit are answered by holding the line low until sample time
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.vh"

module tsr_slot #(
  parameter integer RESET_CYC = `TSR_RESET_CYC,
  parameter integer PRES_CYC  = `TSR_PRES_CYC
)(
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Control
  input  wire       enable,
  input  wire       tx_en,
  input  wire       tx_bit,
  // Line
  input  wire       line_in,
  output reg        drive_low,
  // Events
  output reg        bus_reset,
  output reg        bit_strobe,
  output reg        bit_val
);

  localparam integer SAMPLE_I = `TSR_SAMPLE_CYC;
  localparam integer PWAIT_I  = `TSR_PWAIT_CYC;
  localparam [`TSR_CNT_W-1:0] C_RESET  = RESET_CYC[`TSR_CNT_W-1:0];
  localparam [`TSR_CNT_W-1:0] C_PRES   = PRES_CYC[`TSR_CNT_W-1:0];
  localparam [`TSR_CNT_W-1:0] C_SAMPLE = SAMPLE_I[`TSR_CNT_W-1:0];
  localparam [`TSR_CNT_W-1:0] C_PWAIT  = PWAIT_I[`TSR_CNT_W-1:0];
  localparam [`TSR_CNT_W-1:0] C_MAX    = {`TSR_CNT_W{1'b1}};

  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_LOW   = 2'h1;
  localparam [1:0] S_PWAIT = 2'h2;
  localparam [1:0] S_PRES  = 2'h3;

  reg [1:0]            st_r;
  reg [`TSR_CNT_W-1:0] cnt_r;
  reg                  line_m_r;
  reg                  line_s_r;
  reg                  line_d_r;

  always @(posedge clk)
  begin
    if (rst)
    begin
      st_r       <= S_IDLE;
      cnt_r      <= {`TSR_CNT_W{1'b0}};
      line_m_r   <= 1'b1;
      line_s_r   <= 1'b1;
      line_d_r   <= 1'b1;
      drive_low  <= 1'b0;
      bus_reset  <= 1'b0;
      bit_strobe <= 1'b0;
      bit_val    <= 1'b0;
    end
    else
    begin
      line_m_r   <= line_in;
      line_s_r   <= line_m_r;
      line_d_r   <= line_s_r;
      bus_reset  <= 1'b0;
      bit_strobe <= 1'b0;
      if (!enable)
      begin
        st_r      <= S_IDLE;
        cnt_r     <= {`TSR_CNT_W{1'b0}};
        drive_low <= 1'b0;
      end
      else
      begin
        case (st_r)
          S_IDLE:
          begin
            if (line_d_r && !line_s_r)
            begin
              st_r      <= S_LOW;
              cnt_r     <= {{(`TSR_CNT_W-1){1'b0}}, 1'b1};
              drive_low <= tx_en & ~tx_bit;
            end
          end
          S_LOW:
          begin
            if (cnt_r != C_MAX)
              cnt_r <= cnt_r + {{(`TSR_CNT_W-1){1'b0}}, 1'b1};
            if (cnt_r == C_SAMPLE)
            begin
              // Mid-window sample; a driven read bit is released here too
              bit_strobe <= 1'b1;
              bit_val    <= line_s_r;
              drive_low  <= 1'b0;
            end
            else if (line_s_r && cnt_r > C_SAMPLE)
            begin
              if (cnt_r > C_RESET)
              begin
                bus_reset <= 1'b1;
                st_r      <= S_PWAIT;
                cnt_r     <= {`TSR_CNT_W{1'b0}};
              end
              else
                st_r <= S_IDLE;
            end
          end
          S_PWAIT:
          begin
            cnt_r <= cnt_r + {{(`TSR_CNT_W-1){1'b0}}, 1'b1};
            if (cnt_r == C_PWAIT - 1'b1)
            begin
              st_r      <= S_PRES;
              cnt_r     <= {`TSR_CNT_W{1'b0}};
              drive_low <= 1'b1;
            end
          end
          S_PRES:
          begin
            cnt_r <= cnt_r + {{(`TSR_CNT_W-1){1'b0}}, 1'b1};
            if (cnt_r == C_PRES - 1'b1)
            begin
              st_r      <= S_IDLE;
              drive_low <= 1'b0;
            end
          end
          default:
            st_r <= S_IDLE;
        endcase
      end
    end
  end

endmodule // tsr_slot
`default_nettype wire

/* File: tsr_top.v */
// Purpose: Digital side of a single-pin thermometer and thermostat
// Assumes: Conversion core runs on CORE_CLK; DQ is open drain, pulled up
// Notes:   Bus mode or thermostat mode is chosen once after reset release
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.vh"

module tsr_top #(
  parameter integer RESET_CYC = `TSR_RESET_CYC,
  parameter integer PRES_CYC  = `TSR_PRES_CYC,
  parameter integer NVW_CYC   = `TSR_NVW_CYC
)(
  // Clock and reset
  input  wire       CORE_CLK,
  input  wire       SYS_RST,
  input  wire       NVM_CLEAR,
  // Data pin, open drain
  input  wire       DQ_IN,
  output wire       DQ_OUT,
  output wire       DQ_OE,
  // Conversion core
  output wire       CONV_START,
  input  wire       CONV_VALID,
  input  wire [7:0] CONV_TEMP,
  input  wire [8:0] CONV_REMAIN,
  input  wire [8:0] CONV_SLOPE,
  // Status
  output wire       THERMO_MODE,
  output wire       THERMO_ACTIVE
);

  localparam [1:0] T_IDLE = 2'h0;
  localparam [1:0] T_CMD  = 2'h1;
  localparam [1:0] T_RX   = 2'h2;
  localparam [1:0] T_TX   = 2'h3;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [1:0] st_r;
  reg  [7:0] sh_r;
  reg  [2:0] nbit_r;
  reg  [7:0] cmd_r;
  reg  [8:0] tx_sh_r;
  reg  [3:0] tx_left_r;
  reg  [7:0] temp_r;
  reg  [8:0] count_r;
  reg  [8:0] slope_r;
  reg        conv_run_r;
  reg        conv_busy_r;
  reg        done_r;
  reg        start_r;
  reg        mode_known_r;
  reg        thermo_mode_r;
  reg        thermo_act_r;
  reg        dq_oe_r;
  reg        nvm_wr_r;
  reg  [1:0] nvm_sel_r;
  reg  [7:0] nvm_data_r;
  wire [7:0] sh_nxt;
  wire [7:0] nv_upper;
  wire [7:0] nv_lower;
  wire [4:0] nv_cfg;
  wire       nv_busy;
  wire       slot_drive;
  wire       slot_reset;
  wire       slot_strobe;
  wire       slot_bit;
  wire       above_upper;
  wire       below_lower;
  wire       set_high;
  wire       set_low;
  wire [7:0] status_byte;

  // Data length in bits that a read command returns, zero for others
  function [3:0] tsr_tx_len;
    input [7:0] cmd;
    begin
      case (cmd)
        `TSR_CMD_RD_TEMP,
        `TSR_CMD_RD_UPPER,
        `TSR_CMD_RD_LOWER,
        `TSR_CMD_RD_STATUS: tsr_tx_len = 4'h8;
        `TSR_CMD_RD_COUNT:  tsr_tx_len = 4'h9;
        default:            tsr_tx_len = 4'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  tsr_slot #(
    .RESET_CYC (RESET_CYC),
    .PRES_CYC  (PRES_CYC)
  ) u_slot (
    .clk        (CORE_CLK),
    .rst        (SYS_RST),
    .enable     (mode_known_r & ~thermo_mode_r),
    .tx_en      (st_r == T_TX),
    .tx_bit     (tx_sh_r[0]),
    .line_in    (DQ_IN),
    .drive_low  (slot_drive),
    .bus_reset  (slot_reset),
    .bit_strobe (slot_strobe),
    .bit_val    (slot_bit)
  );

  tsr_nvm #(
    .WRITE_CYC (NVW_CYC)
  ) u_nvm (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .clear    (NVM_CLEAR),
    .wr_en    (nvm_wr_r),
    .wr_sel   (nvm_sel_r),
    .wr_data  (nvm_data_r),
    .set_high (set_high),
    .set_low  (set_low),
    .upper    (nv_upper),
    .lower    (nv_lower),
    .cfg      (nv_cfg),
    .busy     (nv_busy)
  );

  // ----------------------------------------------------------------
  // Comparison of a fresh result
  // ----------------------------------------------------------------
  assign above_upper = $signed(CONV_TEMP) > $signed(nv_upper);
  assign below_lower = $signed(CONV_TEMP) < $signed(nv_lower);
  // Flags land on the same edge as the temperature register
  assign set_high = CONV_VALID & above_upper;
  assign set_low  = CONV_VALID & below_lower;

  assign status_byte = {done_r, 1'b1, nv_busy, nv_cfg};
  assign sh_nxt      = {slot_bit, sh_r[7:1]};

  // ----------------------------------------------------------------
  // Command engine and conversion control
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      st_r          <= T_IDLE;
      sh_r          <= 8'h00;
      nbit_r        <= 3'h0;
      cmd_r         <= 8'h00;
      tx_sh_r       <= 9'h000;
      tx_left_r     <= 4'h0;
      temp_r        <= 8'h00;
      count_r       <= 9'h000;
      slope_r       <= 9'h000;
      conv_run_r    <= 1'b0;
      conv_busy_r   <= 1'b0;
      done_r        <= 1'b0;
      start_r       <= 1'b0;
      mode_known_r  <= 1'b0;
      thermo_mode_r <= 1'b0;
      thermo_act_r  <= 1'b0;
      nvm_wr_r      <= 1'b0;
      nvm_sel_r     <= `TSR_NV_UPPER;
      nvm_data_r    <= 8'h00;
    end
    else
    begin
      start_r  <= 1'b0;
      nvm_wr_r <= 1'b0;

      // Stored mode is taken once, the cycle after reset release
      if (!mode_known_r)
      begin
        mode_known_r  <= 1'b1;
        thermo_mode_r <= nv_cfg[`TSR_ST_MODE];
        if (nv_cfg[`TSR_ST_MODE])
        begin
          conv_run_r  <= 1'b1;
          conv_busy_r <= 1'b1;
          start_r     <= 1'b1;
        end
      end

      if (CONV_VALID)
      begin
        temp_r      <= CONV_TEMP;
        count_r     <= CONV_REMAIN;
        slope_r     <= CONV_SLOPE;
        conv_busy_r <= 1'b0;
        if (above_upper)
          thermo_act_r <= 1'b1;
        else if (below_lower)
          thermo_act_r <= 1'b0;
        if (conv_run_r)
        begin
          start_r     <= 1'b1;
          conv_busy_r <= 1'b1;
        end
        else
          done_r <= 1'b1;
      end

      if (slot_reset)
      begin
        st_r   <= T_CMD;
        nbit_r <= 3'h0;
      end
      else if (slot_strobe)
      begin
        case (st_r)
          T_CMD:
          begin
            sh_r   <= sh_nxt;
            nbit_r <= nbit_r + 3'h1;
            if (nbit_r == 3'h7)
            begin
              cmd_r     <= sh_nxt;
              st_r      <= T_IDLE;
              tx_left_r <= tsr_tx_len(sh_nxt);
              if (tsr_tx_len(sh_nxt) != 4'h0)
                st_r <= T_TX;
              case (sh_nxt)
                `TSR_CMD_RD_TEMP:   tx_sh_r <= {1'b0, temp_r};
                `TSR_CMD_RD_UPPER:  tx_sh_r <= {1'b0, nv_upper};
                `TSR_CMD_RD_LOWER:  tx_sh_r <= {1'b0, nv_lower};
                `TSR_CMD_RD_STATUS: tx_sh_r <= {1'b0, status_byte};
                `TSR_CMD_RD_COUNT:  tx_sh_r <= count_r;
                `TSR_CMD_LD_COUNT:  count_r <= slope_r;
                `TSR_CMD_WR_UPPER,
                `TSR_CMD_WR_LOWER,
                `TSR_CMD_WR_STATUS: st_r <= T_RX;
                `TSR_CMD_START:
                begin
                  done_r     <= 1'b0;
                  conv_run_r <= ~nv_cfg[`TSR_ST_SINGLE];
                  if (!conv_busy_r)
                  begin
                    start_r     <= 1'b1;
                    conv_busy_r <= 1'b1;
                  end
                end
                `TSR_CMD_STOP:
                begin
                  // A one-shot run is not cut short by stop
                  if (!nv_cfg[`TSR_ST_SINGLE])
                    conv_run_r <= 1'b0;
                end
                default:
                  tx_sh_r <= tx_sh_r;
              endcase
            end
          end
          T_RX:
          begin
            sh_r   <= sh_nxt;
            nbit_r <= nbit_r + 3'h1;
            if (nbit_r == 3'h7)
            begin
              st_r       <= T_IDLE;
              nvm_wr_r   <= 1'b1;
              nvm_data_r <= sh_nxt;
              case (cmd_r)
                `TSR_CMD_WR_UPPER: nvm_sel_r <= `TSR_NV_UPPER;
                `TSR_CMD_WR_LOWER: nvm_sel_r <= `TSR_NV_LOWER;
                default:           nvm_sel_r <= `TSR_NV_CFG;
              endcase
            end
          end
          T_TX:
          begin
            tx_sh_r   <= {1'b0, tx_sh_r[8:1]};
            tx_left_r <= tx_left_r - 4'h1;
            if (tx_left_r == 4'h1)
              st_r <= T_IDLE;
          end
          default:
            st_r <= T_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // In thermostat mode the pin is low when the output level is low,
  // i.e. when the active state and the sense bit differ.
  always @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      dq_oe_r <= 1'b0;
    else if (thermo_mode_r)
      dq_oe_r <= thermo_act_r ^ nv_cfg[`TSR_ST_SENSE];
    else
      dq_oe_r <= slot_drive;
  end

  assign DQ_OUT        = 1'b0;
  assign DQ_OE         = dq_oe_r;
  assign CONV_START    = start_r;
  assign THERMO_MODE   = thermo_mode_r;
  assign THERMO_ACTIVE = thermo_act_r;

endmodule // tsr_top
`default_nettype wire

/* File: tsr_top_monitor.sv */
// Purpose: Port checker for tsr_top
// Assumes: One clock domain; SYS_RST synchronous, active high
// Notes:   Trip points are internal, so timing relations are watched here
`timescale 1ns/1ps
`default_nettype none
module tsr_top_monitor #(
  parameter integer PRES_CYC = 12000
)(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Line and core
  input wire logic DQ_OUT,
  input wire logic DQ_OE,
  input wire logic CONV_START,
  input wire logic CONV_VALID,
  // Status
  input wire logic THERMO_MODE,
  input wire logic THERMO_ACTIVE
);
  // Longest pull is presence, or a read-0 answer held to the sample point
  localparam int OE_MAX = PRES_CYC + 3005;
  logic [31:0] oe_run_r;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  always_ff @(posedge CORE_CLK)
    oe_run_r <= (SYS_RST || !DQ_OE || THERMO_MODE) ? 32'h0 : oe_run_r + 32'h1;
  sequence s_thermo_result;
    THERMO_MODE && CONV_VALID;
  endsequence
  sequence s_mode_entry;
    $rose(THERMO_MODE);
  endsequence
  chk_oe_reset: assert property (disable iff (1'h0) SYS_RST |=> !DQ_OE)
    else $error("line pulled low after reset");
  chk_dq_constant: assert property (DQ_OUT == 1'h0)
    else $error("data output not held low");
  chk_oe_bounded: assert property (oe_run_r <= OE_MAX)
    else $error("line held low too long");
  chk_start_pulse: assert property (CONV_START |=> !CONV_START)
    else $error("start request longer than one cycle");
  chk_mode_latch: assert property ($changed(THERMO_MODE) |-> $past(SYS_RST, 2))
    else $error("mode changed outside reset release");
  chk_mode_start: assert property (s_mode_entry |-> CONV_START)
    else $error("no conversion at thermostat entry");
  chk_cont_conv: assert property (s_thermo_result |=> CONV_START)
    else $error("conversions not back to back");
  chk_act_cause: assert property (!$past(SYS_RST) && $changed(THERMO_ACTIVE)
    |-> $past(CONV_VALID)) else $error("output state changed without a result");
  chk_sense_hold: assert property (THERMO_MODE && $past(THERMO_MODE, 3)
    && $stable(THERMO_ACTIVE) && $past(THERMO_ACTIVE) == $past(THERMO_ACTIVE, 2)
    |-> $stable(DQ_OE)) else $error("pin moved while output state held");
endmodule // tsr_top_monitor
bind tsr_top tsr_top_monitor #(.PRES_CYC(PRES_CYC)) u_mon (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
  .CONV_START(CONV_START), .CONV_VALID(CONV_VALID),
  .THERMO_MODE(THERMO_MODE), .THERMO_ACTIVE(THERMO_ACTIVE));
`default_nettype wire
